// ===== src/cbbr_defs.svh
// offsets, field positions, reset values and decode constants of the bridge control block
`ifndef CBBR_DEFS_SVH
`define CBBR_DEFS_SVH

// ----------------------------------------------------------------
// configuration space offsets (byte addresses)
// ----------------------------------------------------------------
`define CBBR_OFS_BCTL 8'h3E
`define CBBR_OFS_SVID 8'h40
`define CBBR_OFS_SID 8'h42

// ----------------------------------------------------------------
// bridge control field positions
// ----------------------------------------------------------------
`define CBBR_BIT_POST 10
`define CBBR_BIT_WIN1 9
`define CBBR_BIT_WIN0 8
`define CBBR_BIT_ROUTE 7
`define CBBR_BIT_CARD_RESET_DRIVE 6
`define CBBR_BIT_MABT 5
`define CBBR_BIT_VGA 3
`define CBBR_BIT_ISA 2
`define CBBR_BIT_SERR 1
`define CBBR_BIT_PERR 0

// ----------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------
`define CBBR_BCTL_RESET 16'h0340
`define CBBR_BCTL_SOCK_MASK 16'h07CF
`define CBBR_SVID_RESET 16'h0000
`define CBBR_SID_RESET 16'h0000

// ----------------------------------------------------------------
// forwarding decode
// ----------------------------------------------------------------
`define CBBR_VGA_MEM_LO 32'h000A0000
`define CBBR_VGA_MEM_HI 32'h000BFFFF
`define CBBR_VGA_IO0_LO 32'h000003B0
`define CBBR_VGA_IO0_HI 32'h000003BB
`define CBBR_VGA_IO1_LO 32'h000003C0
`define CBBR_VGA_IO1_HI 32'h000003DF

`endif

// ===== src/cbbr_pkg.sv
// shared types of the bridge control block
package cbbr_pkg;
  typedef logic [15:0] cbbr_word_type;
  typedef enum logic {CBBR_FUNC0 = 1'b0, CBBR_FUNC1 = 1'b1} cbbr_func_type;
endpackage : cbbr_pkg

// ===== src/cbbr_func_regs.sv
// per-function register set: socket bits of bridge control and subsystem identification
`timescale 1ns/1ps
`include "cbbr_defs.svh"

module cbbr_func_regs
  import cbbr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // host writes, byte lanes of the two words
  input wire logic [1:0] bctl_we,
  input wire logic [3:0] id_we,
  input wire logic [31:0] wdata,
  input wire logic id_write_enable,
  // eeprom load
  input wire logic ee_load,
  input wire cbbr_word_type ee_svid,
  input wire cbbr_word_type ee_sid,
  // stored values
  output cbbr_word_type bctl_reg,
  output cbbr_word_type svid_reg,
  output cbbr_word_type sid_reg
);

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  cbbr_word_type bctl_wr;
  cbbr_word_type bctl_next;
  cbbr_word_type svid_next;
  cbbr_word_type sid_next;
  logic [3:0] id_lane_we;

  assign bctl_wr[7:0] = bctl_we[0] ? wdata[23:16] : bctl_reg[7:0];
  assign bctl_wr[15:8] = bctl_we[1] ? wdata[31:24] : bctl_reg[15:8];
  // reserved and global bits never land here
  assign bctl_next = bctl_wr & `CBBR_BCTL_SOCK_MASK;

  // writes while the enable is clear are dropped
  assign id_lane_we = id_write_enable ? id_we : 4'h0;

  // eeprom load wins over a host write in the same cycle
  assign svid_next = ee_load ? ee_svid :
    {id_lane_we[1] ? wdata[15:8] : svid_reg[15:8], id_lane_we[0] ? wdata[7:0] : svid_reg[7:0]};
  assign sid_next = ee_load ? ee_sid :
    {id_lane_we[3] ? wdata[31:24] : sid_reg[15:8], id_lane_we[2] ? wdata[23:16] : sid_reg[7:0]};

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bctl_reg <= `CBBR_BCTL_RESET & `CBBR_BCTL_SOCK_MASK;
      svid_reg <= `CBBR_SVID_RESET;
      sid_reg <= `CBBR_SID_RESET;
    end else begin
      bctl_reg <= bctl_next;
      svid_reg <= svid_next;
      sid_reg <= sid_next;
    end
  end

endmodule : cbbr_func_regs

// ===== src/cbbr_regs.sv
// bridge control and subsystem identification registers of a two-socket cardbus bridge
`timescale 1ns/1ps
`include "cbbr_defs.svh"

// Behaviour
// - bits 15 to 11 of bridge control read zero, writes ignored
// - write posting enable kept per socket, posts burst writes
// - window 1 prefetchable when bit set, reset one, per socket
// - window 0 prefetchable when bit set, reset one
// - routing bit zero sends card interrupts to pci, one to legacy irq
// - card reset follows its control bit, which resets to one
// - card reset also asserted while the pci bus reset is asserted
// - master abort on card side reported as target abort if mode set, and as serr only if serr_enable is also set
// - abort mode bit is global, written only through function 0
// - bit 4 of bridge control reads zero
// - vga enable forwards vga address ranges across the bridge
// - isa filter blocks upper 768 bytes of each 1k in lowest 64k io
// - card system error forwarded to pci serr only when enabled
// - card parity errors reported on card parity line only when enabled
// - subsystem words writable only while the system write enable is set
// - subsystem words loaded from eeprom after reset when present
module cbbr_regs
  import cbbr_pkg::*;
(
  // clock and pci bus reset
  input wire logic clk,
  input wire logic arst_n,
  // configuration access
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire cbbr_func_type cfg_func,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  // system settings
  input wire logic subsystem_ident_write_enable,
  input wire logic serr_enable,
  // eeprom load
  input wire logic ee_load,
  input wire cbbr_func_type ee_func,
  input wire cbbr_word_type ee_svid,
  input wire cbbr_word_type ee_sid,
  // card side events and forwarding queries
  input wire logic [1:0] cb_master_abort,
  input wire logic [1:0] card_syserr,
  input wire logic [1:0] card_parity_err,
  input wire logic [31:0] fwd_addr,
  input wire logic fwd_is_io,
  // per socket controls and the global abort mode
  output logic [1:0] write_posting_enable,
  output logic [1:0] window1_prefetchable,
  output logic [1:0] window0_prefetchable,
  output logic [1:0] functional_irq_route_select,
  output logic [1:0] card_reset,
  output logic [1:0] vga_forward_enable,
  output logic [1:0] isa_range_filter_enable,
  output logic [1:0] card_syserr_forward_enable,
  output logic [1:0] card_parity_response_enable,
  output logic master_abort_report_mode,
  // forwarding and error outputs
  output logic [1:0] vga_forward,
  output logic [1:0] io_forward_block,
  output logic pci_target_abort,
  output logic pci_serr,
  output logic [1:0] card_perr
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_BCTL = `CBBR_OFS_BCTL;
  localparam logic [7:0] OFS_SVID = `CBBR_OFS_SVID;

  wire hit_bctl = cfg_addr[7:2] == OFS_BCTL[7:2];
  wire hit_ids = cfg_addr[7:2] == OFS_SVID[7:2];
  wire wr_go = cfg_req && cfg_we;
  wire rd_go = cfg_req && !cfg_we;
  wire wr_f0 = wr_go && (cfg_func == CBBR_FUNC0);
  wire wr_f1 = wr_go && (cfg_func == CBBR_FUNC1);
  wire [1:0] bctl_lanes = hit_bctl ? cfg_be[3:2] : 2'b00;
  wire [3:0] id_lanes = hit_ids ? cfg_be : 4'h0;
  wire [1:0] bctl_we0 = wr_f0 ? bctl_lanes : 2'b00;
  wire [1:0] bctl_we1 = wr_f1 ? bctl_lanes : 2'b00;
  wire [3:0] id_we0 = wr_f0 ? id_lanes : 4'h0;
  wire [3:0] id_we1 = wr_f1 ? id_lanes : 4'h0;
  wire ee_load0 = ee_load && (ee_func == CBBR_FUNC0);
  wire ee_load1 = ee_load && (ee_func == CBBR_FUNC1);

  // ----------------------------------------------------------------
  // per function storage
  // ----------------------------------------------------------------
  cbbr_word_type bctl0;
  cbbr_word_type bctl1;
  cbbr_word_type svid0;
  cbbr_word_type svid1;
  cbbr_word_type sid0;
  cbbr_word_type sid1;

  cbbr_func_regs u_func0 (
    .clk(clk),
    .arst_n(arst_n),
    .bctl_we(bctl_we0),
    .id_we(id_we0),
    .wdata(cfg_wdata),
    .id_write_enable(subsystem_ident_write_enable),
    .ee_load(ee_load0),
    .ee_svid(ee_svid),
    .ee_sid(ee_sid),
    .bctl_reg(bctl0),
    .svid_reg(svid0),
    .sid_reg(sid0)
  );

  cbbr_func_regs u_func1 (
    .clk(clk),
    .arst_n(arst_n),
    .bctl_we(bctl_we1),
    .id_we(id_we1),
    .wdata(cfg_wdata),
    .id_write_enable(subsystem_ident_write_enable),
    .ee_load(ee_load1),
    .ee_svid(ee_svid),
    .ee_sid(ee_sid),
    .bctl_reg(bctl1),
    .svid_reg(svid1),
    .sid_reg(sid1)
  );

  // per socket bits straight from the function flops
  assign write_posting_enable = {bctl1[`CBBR_BIT_POST], bctl0[`CBBR_BIT_POST]};
  assign window1_prefetchable = {bctl1[`CBBR_BIT_WIN1], bctl0[`CBBR_BIT_WIN1]};
  assign window0_prefetchable = {bctl1[`CBBR_BIT_WIN0], bctl0[`CBBR_BIT_WIN0]};
  assign functional_irq_route_select = {bctl1[`CBBR_BIT_ROUTE], bctl0[`CBBR_BIT_ROUTE]};
  assign vga_forward_enable = {bctl1[`CBBR_BIT_VGA], bctl0[`CBBR_BIT_VGA]};
  assign isa_range_filter_enable = {bctl1[`CBBR_BIT_ISA], bctl0[`CBBR_BIT_ISA]};
  assign card_syserr_forward_enable = {bctl1[`CBBR_BIT_SERR], bctl0[`CBBR_BIT_SERR]};
  assign card_parity_response_enable = {bctl1[`CBBR_BIT_PERR], bctl0[`CBBR_BIT_PERR]};

  // ----------------------------------------------------------------
  // global abort mode and card reset
  // ----------------------------------------------------------------
  logic mabt_mode_reg;
  logic mabt_mode_next;
  logic [1:0] card_reset_reg;
  logic [1:0] card_reset_next;

  // function 1 cannot touch the shared bit
  assign mabt_mode_next = bctl_we0[0] ? cfg_wdata[16 + `CBBR_BIT_MABT] : mabt_mode_reg;
  assign card_reset_next = {bctl1[`CBBR_BIT_CARD_RESET_DRIVE], bctl0[`CBBR_BIT_CARD_RESET_DRIVE]};

  // pci reset forces the card into reset regardless of the control bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mabt_mode_reg <= 1'b0;
      card_reset_reg <= 2'b11;
    end else begin
      mabt_mode_reg <= mabt_mode_next;
      card_reset_reg <= card_reset_next;
    end
  end

  assign master_abort_report_mode = mabt_mode_reg;
  assign card_reset = card_reset_reg;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  wire [15:0] bctl_sel = (cfg_func == CBBR_FUNC0) ? bctl0 : bctl1;
  wire [15:0] bctl_view = bctl_sel | (16'(mabt_mode_reg) << `CBBR_BIT_MABT);
  wire [31:0] ids_view = (cfg_func == CBBR_FUNC0) ? {sid0, svid0} : {sid1, svid1};
  wire [31:0] rd_word = hit_bctl ? {bctl_view, 16'h0000} : hit_ids ? ids_view : 32'h00000000;

  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // read data holds until the next read so a slow host may sample late
  assign rdata_next = rd_go ? rd_word : rdata_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= cfg_req;
      rdata_reg <= rdata_next;
    end
  end

  assign cfg_ack = ack_reg;
  assign cfg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // forwarding decode
  // ----------------------------------------------------------------
  wire vga_mem_hit = !fwd_is_io && fwd_addr >= `CBBR_VGA_MEM_LO && fwd_addr <= `CBBR_VGA_MEM_HI;
  wire vga_io0_hit = fwd_is_io && fwd_addr >= `CBBR_VGA_IO0_LO && fwd_addr <= `CBBR_VGA_IO0_HI;
  wire vga_io1_hit = fwd_is_io && fwd_addr >= `CBBR_VGA_IO1_LO && fwd_addr <= `CBBR_VGA_IO1_HI;
  wire vga_hit = vga_mem_hit || vga_io0_hit || vga_io1_hit;
  // upper 768 bytes of a 1k block: address bits 9:8 not both zero
  wire isa_alias = fwd_is_io && (fwd_addr[31:16] == 16'h0000) && (fwd_addr[9:8] != 2'b00);

  // ----------------------------------------------------------------
  // error reporting
  // ----------------------------------------------------------------
  wire tabort_next = mabt_mode_reg && (cb_master_abort != 2'b00);
  wire syserr_fwd = (card_syserr & card_syserr_forward_enable) != 2'b00;
  wire serr_next = syserr_fwd || (tabort_next && serr_enable);

  logic [1:0] vga_fwd_reg;
  logic [1:0] io_block_reg;
  logic tabort_reg;
  logic serr_reg;
  logic [1:0] perr_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vga_fwd_reg <= 2'b00;
      io_block_reg <= 2'b00;
      tabort_reg <= 1'b0;
      serr_reg <= 1'b0;
      perr_reg <= 2'b00;
    end else begin
      vga_fwd_reg <= vga_forward_enable & {2{vga_hit}};
      io_block_reg <= isa_range_filter_enable & {2{isa_alias}};
      tabort_reg <= tabort_next;
      serr_reg <= serr_next;
      perr_reg <= card_parity_err & card_parity_response_enable;
    end
  end

  assign vga_forward = vga_fwd_reg;
  assign io_forward_block = io_block_reg;
  assign pci_target_abort = tabort_reg;
  assign pci_serr = serr_reg;
  assign card_perr = perr_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb_chk @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic [7:0] last_addr_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last_addr_reg <= 8'h00;
    end else if (rd_go) begin
      last_addr_reg <= cfg_addr;
    end
  end

  sequence card_reset_drive_write0;
    bctl_we0[0] ##1 1'b1;
  endsequence

  property card_reset_drive_follows;
    logic bit_val;
    (card_reset_drive_write0, bit_val = $past(cfg_wdata[16 + `CBBR_BIT_CARD_RESET_DRIVE])) |=> card_reset[0] == bit_val;
  endproperty

  resv_read_zero_a: assert property (
    cfg_ack && last_addr_reg[7:2] == OFS_BCTL[7:2] |-> cfg_rdata[31:27] == 5'h00
  ) else $error("reserved bridge control bits read nonzero");
  bit4_read_zero_a: assert property (
    cfg_ack && last_addr_reg[7:2] == OFS_BCTL[7:2] |-> cfg_rdata[20] == 1'b0
  ) else $error("bridge control bit 4 reads nonzero");
  posting_private_a: assert property (
    bctl_we1[1] && !bctl_we0[1] |=> $stable(write_posting_enable[0])
  ) else $error("function 1 write changed socket 0 posting");
  win_type_write_a: assert property (
    bctl_we0[1] |=> window1_prefetchable[0] == $past(cfg_wdata[24 + `CBBR_BIT_WIN1 - 8])
      && window0_prefetchable[0] == $past(cfg_wdata[24 + `CBBR_BIT_WIN0 - 8])
  ) else $error("window type bits not written");
  route_write_a: assert property (
    bctl_we1[0] |=> functional_irq_route_select[1] == $past(cfg_wdata[16 + `CBBR_BIT_ROUTE])
  ) else $error("route select not written");
  card_reset_seq_a: assert property (card_reset_drive_follows)
    else $error("card reset does not follow its bit");
  abort_report_a: assert property (
    cb_master_abort[0] |=> pci_target_abort == $past(mabt_mode_reg)
  ) else $error("master abort report wrong");
  abort_global_a: assert property (
    bctl_we1[0] && !bctl_we0[0] |=> $stable(master_abort_report_mode)
  ) else $error("function 1 changed abort mode");
  isa_block_a: assert property (
    fwd_is_io && fwd_addr == 32'h00000300 |=> io_forward_block == $past(isa_range_filter_enable)
  ) else $error("isa alias block wrong");
  syserr_fwd_a: assert property (
    card_syserr[1] && card_syserr_forward_enable[1] |=> pci_serr
  ) else $error("card system error not forwarded");
  parity_gate_a: assert property (
    card_parity_err[0] |=> card_perr[0] == $past(card_parity_response_enable[0])
  ) else $error("parity report gating wrong");
  id_locked_a: assert property (
    !subsystem_ident_write_enable && !ee_load |=> $stable(svid0) && $stable(sid1)
  ) else $error("locked subsystem word changed");
  ee_load_a: assert property (
    ee_load0 |=> svid0 == $past(ee_svid) && sid0 == $past(ee_sid)
  ) else $error("eeprom load not taken");

endmodule : cbbr_regs

// ===== dv/cbbr_card_model.sv
// card socket and eeprom model on the far side of the bridge control block
`timescale 1ns/1ps
module cbbr_card_model
  import cbbr_pkg::*;
(
  // clock
  input wire logic clk,
  // card events, one bit per socket
  output logic [1:0] cb_master_abort,
  output logic [1:0] card_syserr,
  output logic [1:0] card_parity_err,
  // eeprom load
  output logic ee_load,
  output cbbr_func_type ee_func,
  output cbbr_word_type ee_svid,
  output cbbr_word_type ee_sid
);
  initial begin
    {cb_master_abort, card_syserr, card_parity_err, ee_load} = 7'h00;
    ee_func = CBBR_FUNC0;
    {ee_svid, ee_sid} = 32'h00000000;
  end
  // one-cycle card event: kind 0 master abort, 1 system error, 2 parity error
  task automatic pulse(input int kind, input int sock);
    @(negedge clk);
    if (kind == 0) cb_master_abort[sock] = 1'b1;
    if (kind == 1) card_syserr[sock] = 1'b1;
    if (kind == 2) card_parity_err[sock] = 1'b1;
    @(negedge clk);
    {cb_master_abort, card_syserr, card_parity_err} = 6'h00;
  endtask : pulse
  // one-cycle strobe; the data lines then toggle so stale words never look valid
  task automatic ee_send(input cbbr_func_type f, input cbbr_word_type v, input cbbr_word_type d);
    @(negedge clk);
    ee_load = 1'b1;
    ee_func = f;
    {ee_svid, ee_sid} = {v, d};
    @(negedge clk);
    ee_load = 1'b0;
    {ee_svid, ee_sid} = ~{v, d};
  endtask : ee_send
endmodule : cbbr_card_model

// ===== dv/cbbr_regs_tb_top.sv
// self-checking bench of the bridge control and subsystem identification registers
`timescale 1ns/1ps
`include "cbbr_defs.svh"
module cbbr_regs_tb_top
  import cbbr_pkg::*;
;
  typedef struct {logic chk; logic [31:0] d;} cbbr_note_type;
  logic clk = 1'b0;
  logic arst_n, cfg_req, cfg_we, cfg_ack, subsystem_ident_write_enable, serr_enable, fwd_is_io;
  cbbr_func_type cfg_func, ee_func;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, fwd_addr;
  cbbr_word_type ee_svid, ee_sid, bx[2], svx[2], six[2];
  logic ee_load, master_abort_report_mode, pci_target_abort, pci_serr, mx, f;
  logic [1:0] cb_master_abort, card_syserr, card_parity_err, card_perr, vga_forward;
  logic [1:0] io_forward_block, write_posting_enable, window1_prefetchable, card_reset;
  logic [1:0] window0_prefetchable, functional_irq_route_select, vga_forward_enable;
  logic [1:0] isa_range_filter_enable, card_syserr_forward_enable, card_parity_response_enable;
  logic [32:0] tab [14] = '{33'h1000003AF, 33'h1000003B0, 33'h1000003BB, 33'h1000003BC,
    33'h1000003DF, 33'h1000003E0, 33'h0000A0000, 33'h00009FFFF, 33'h0000BFFFF,
    33'h0000C0000, 33'h1000000FF, 33'h100000100, 33'h100010100, 33'h100000400};
  int error_cnt = 0, n_compared = 0, cyc = 0;
  cbbr_note_type q[$];
  cbbr_note_type nt;

  always #12.5 clk = ~clk;

  cbbr_regs cbbr_regs_inst (.clk(clk), .arst_n(arst_n), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_func(cfg_func), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .serr_enable(serr_enable),
    .subsystem_ident_write_enable(subsystem_ident_write_enable), .ee_load(ee_load),
    .ee_func(ee_func), .ee_svid(ee_svid), .ee_sid(ee_sid), .cb_master_abort(cb_master_abort),
    .card_syserr(card_syserr), .card_parity_err(card_parity_err), .fwd_addr(fwd_addr),
    .fwd_is_io(fwd_is_io), .write_posting_enable(write_posting_enable),
    .window1_prefetchable(window1_prefetchable), .window0_prefetchable(window0_prefetchable),
    .functional_irq_route_select(functional_irq_route_select), .card_reset(card_reset),
    .vga_forward_enable(vga_forward_enable), .isa_range_filter_enable(isa_range_filter_enable),
    .card_syserr_forward_enable(card_syserr_forward_enable),
    .card_parity_response_enable(card_parity_response_enable),
    .master_abort_report_mode(master_abort_report_mode), .vga_forward(vga_forward),
    .io_forward_block(io_forward_block), .pci_target_abort(pci_target_abort),
    .pci_serr(pci_serr), .card_perr(card_perr));

  cbbr_card_model cbbr_card_model_inst (.clk(clk), .cb_master_abort(cb_master_abort),
    .card_syserr(card_syserr), .card_parity_err(card_parity_err), .ee_load(ee_load),
    .ee_func(ee_func), .ee_svid(ee_svid), .ee_sid(ee_sid));

  // ----------------------------------------------------------------
  // expected register state
  // ----------------------------------------------------------------
  function automatic void mreset();
    bx = '{16'h0340, 16'h0340};
    {svx[0], svx[1], six[0], six[1], mx} = 65'h0;
  endfunction : mreset
  function automatic void mwr(logic fn, logic [7:0] a, logic [3:0] be, logic [31:0] d);
    if (a[7:2] == 6'h0F && be[2]) bx[fn][7:0] = d[23:16] & 8'hCF;
    if (a[7:2] == 6'h0F && be[3]) bx[fn][15:8] = d[31:24] & 8'h07;
    if (a[7:2] == 6'h0F && be[2] && !fn) mx = d[21];
    if (a[7:2] == 6'h10 && subsystem_ident_write_enable) begin
      for (int l = 0; l < 2; l++) begin
        if (be[l]) svx[fn][8*l+:8] = d[8*l+:8];
        if (be[l+2]) six[fn][8*l+:8] = d[8*l+16+:8];
      end
    end
  endfunction : mwr
  function automatic logic [31:0] erd(logic fn, logic [7:0] a);
    if (a[7:2] == 6'h0F) return {bx[fn] | {10'h000, mx, 5'h00}, 16'h0000};
    if (a[7:2] == 6'h10) return {six[fn], svx[fn]};
    return 32'h00000000;
  endfunction : erd
  function automatic logic vexp(int s);
    if (fwd_is_io) return bx[s][3] && ((fwd_addr >= `CBBR_VGA_IO0_LO && fwd_addr <= `CBBR_VGA_IO0_HI)
      || (fwd_addr >= `CBBR_VGA_IO1_LO && fwd_addr <= `CBBR_VGA_IO1_HI));
    return bx[s][3] && fwd_addr >= `CBBR_VGA_MEM_LO && fwd_addr <= `CBBR_VGA_MEM_HI;
  endfunction : vexp
  function automatic logic bexp(int s);
    return bx[s][2] && fwd_is_io && fwd_addr < 32'h00010000 && fwd_addr[9:8] != 2'h0;
  endfunction : bexp

  // ----------------------------------------------------------------
  // drivers, comparisons and verdict
  // ----------------------------------------------------------------
  task automatic cmp(string what, logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic acc(logic fn, logic w, logic [7:0] a, logic [3:0] be, logic [31:0] d,
                     logic c, logic [31:0] e);
    @(negedge clk);
    {cfg_req, cfg_we, cfg_addr, cfg_be, cfg_wdata} = {1'b1, w, a, be, d};
    cfg_func = cbbr_func_type'(fn);
    q.push_back('{c, e});
    if (w) mwr(fn, a, be, d);
  endtask : acc
  task automatic rd(logic fn, logic [7:0] a);
    acc(fn, 1'b0, a, 4'hF, 32'h00000000, 1'b1, erd(fn, a));
  endtask : rd
  // drop the request after the one edge that takes it, or the access repeats
  task automatic idle(int n);
    @(negedge clk);
    cfg_req = 1'b0;
    repeat (n - 1) @(negedge clk);
  endtask : idle
  task automatic chk_ctl();
    for (int s = 0; s < 2; s++) begin
      cmp("ctl", 32'({write_posting_enable[s], window1_prefetchable[s], window0_prefetchable[s],
        functional_irq_route_select[s], card_reset[s], vga_forward_enable[s],
        isa_range_filter_enable[s], card_syserr_forward_enable[s],
        card_parity_response_enable[s]}), 32'({bx[s][10:6], bx[s][3:0]}));
    end
    cmp("abort mode", 32'(master_abort_report_mode), 32'(mx));
  endtask : chk_ctl
  task automatic finish_test();
    if (q.size() != 0) begin
      error_cnt++;
      $display("unexpected %0t: %0d accesses never acknowledged", $time, q.size());
    end
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  // read results are checked in order of issue, whenever an acknowledge shows
  always @(negedge clk) begin
    if (cfg_ack === 1'b1 && q.size() == 0) begin
      error_cnt++;
      $display("unexpected %0t: acknowledge without a pending access", $time);
    end else if (cfg_ack === 1'b1) begin
      nt = q.pop_front();
      if (nt.chk === 1'b1) cmp("read", cfg_rdata, nt.d);
    end
  end
  // the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(78094));
    {arst_n, cfg_req, cfg_we, subsystem_ident_write_enable, serr_enable, fwd_is_io} = 6'h00;
    cfg_func = CBBR_FUNC0;
    {cfg_addr, cfg_be, cfg_wdata, fwd_addr} = 76'h0;
    mreset();
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    rd(0, 8'h3C);
    rd(1, 8'h40);
    acc(0, 1, 8'h3E, 4'hC, 32'hFFFF0000, 0, 0);
    rd(0, 8'h3C);
    acc(1, 1, 8'h3C, 4'hC, 32'h00000000, 0, 0);
    rd(1, 8'h3C);
    acc(0, 1, 8'h44, 4'hF, 32'hFFFFFFFF, 0, 0);
    rd(0, 8'h44);
    idle(2);
    chk_ctl();
    repeat (12) begin
      f = 1'($urandom);
      acc(f, 1, 8'h3C, 4'($urandom), $urandom, 0, 0);
      rd(f, 8'h3C);
    end
    idle(2);
    chk_ctl();
    acc(0, 1, 8'h40, 4'hF, 32'h12345678, 0, 0);
    rd(0, 8'h40);
    idle(1);
    subsystem_ident_write_enable = 1'b1;
    acc(1, 1, 8'h40, 4'h5, 32'hA1B2C3D4, 0, 0);
    rd(1, 8'h40);
    idle(1);
    cbbr_card_model_inst.ee_send(CBBR_FUNC0, 16'h5A5A, 16'hC3C3);
    {svx[0], six[0]} = 32'h5A5AC3C3;
    rd(0, 8'h40);
    rd(1, 8'h40);
    for (int i = 0; i < 8; i++) begin
      idle(1);
      serr_enable = i[1];
      acc(i[0], 1, 8'h3C, 4'h4, i[2] ? 32'h00230000 : 32'h00000000, 0, 0);
      idle(1);
      for (int k = 0; k < 3; k++) begin
        cbbr_card_model_inst.pulse(k, i % 2);
        cmp("events", 32'({pci_target_abort, pci_serr, card_perr}), 32'({k == 0 && mx,
          (k == 0 && mx && serr_enable) || (k == 1 && bx[i % 2][1]),
          (k == 2 && bx[i % 2][0]) ? 2'(1 << (i % 2)) : 2'h0}));
      end
    end
    acc(0, 1, 8'h3C, 4'h4, 32'h000C0000, 0, 0);
    acc(1, 1, 8'h3C, 4'h4, 32'h00080000, 0, 0);
    idle(1);
    for (int i = 0; i < 30; i++) begin
      @(negedge clk);
      {fwd_is_io, fwd_addr} = (i < 14) ? tab[i] :
        {i[0], $urandom & (i[0] ? 32'h000107FF : 32'h000FFFFF)};
      @(negedge clk);
      cmp("forward", 32'({vga_forward, io_forward_block}),
        32'({vexp(1), vexp(0), bexp(1), bexp(0)}));
    end
    acc(0, 1, 8'h3C, 4'h4, 32'h00000000, 0, 0);
    acc(1, 1, 8'h3C, 4'h4, 32'h00000000, 0, 0);
    idle(3);
    chk_ctl();
    arst_n = 1'b0;
    #1;
    cmp("reset card", 32'(card_reset), 32'h00000003);
    mreset();
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    rd(1, 8'h3C);
    rd(0, 8'h40);
    idle(2);
    chk_ctl();
    finish_test();
  end
endmodule : cbbr_regs_tb_top
